// *** hdl/fpd_consts.svh ***
// Constants for the floating-point dispatch and compatibility block
// Overview of operation
// RL1 - Legacy interrupt enable/disable and protected-mode notify opcodes complete as no-ops.
// RL2 - Examine on an empty register never reports condition code 1101 or 1111.
// RL3 - State-save pointer may be undefined when the prior instruction had no memory.
// RL4 - Transcendental error below 1 ulp round-nearest, below 1.5 ulps otherwise.
// RL5 - Transcendental results stay monotonic across the supported input domain.
// RL6 - A pending exception is reported on the wait instruction itself.
// RL7 - A split store whose second half faults may commit only the first half.
// RL8 - Each floating-point instruction waits for the previous one to complete.
// RL9 - A serializing instruction completes only after all earlier work is committed.
// RL10 - After reset, sample the coprocessor error input to detect the coprocessor type.
// RL11 - The coprocessor holds its error output at a type-identifying level after reset.
// RL12 - Neither reset nor the init operation raises a floating-point error.
// RL13 - Emulate flag set traps floating-point instructions; clear passes them to the unit.
// RL14 - Monitor flag set makes wait-type instructions test the task-switched flag.
// RL15 - Control word store returns FFFF without a unit and 037F with one.
// RL16 - Software sets emulate, monitor and numeric-error flags per the presence of a unit.
// RL17 - Under emulation every floating-point instruction raises device-not-available, vector 7.
// RL18 - Numeric-error flag selects internal error reporting instead of the external pin.
// RL19 - Wait with monitor and task-switched set traps before touching any unit state.
`ifndef FPD_CONSTS_SVH
`define FPD_CONSTS_SVH

`define FPD_CLK_NS      4
`define FPD_DETECT_NS   64

`define FPD_REG_CTRL    2'h0
`define FPD_REG_STATUS  2'h1
`define FPD_REG_INTSTAT 2'h2
`define FPD_REG_INTMASK 2'h3

`define FPD_CTRL_EMU    0
`define FPD_CTRL_MON    1
`define FPD_CTRL_NE     2
`define FPD_CTRL_TS     3
`define FPD_CTRL_RESET  4'h0

`define FPD_INT_TRAP    0
`define FPD_INT_EXC     1
`define FPD_INT_DETECT  2

`define FPD_CW_NONE     16'hffff
`define FPD_CW_PRESENT  16'h037f
`define FPD_VEC_DNA     8'h07
`define FPD_VEC_MF      8'h10
`define FPD_CC_EMPTY    4'h5
`define FPD_CC_BAD_A    4'hd
`define FPD_CC_BAD_B    4'hf

`endif

// *** hdl/fpd_pkg.sv ***
// Types shared by the floating-point dispatch block
`default_nettype none
package fpd_pkg;
   typedef enum logic [3:0] {
      FPD_OP_LEGACY  = 4'h0,
      FPD_OP_SERIAL  = 4'h1,
      FPD_OP_WAIT    = 4'h2,
      FPD_OP_ARITH   = 4'h3,
      FPD_OP_TRANSC  = 4'h4,
      FPD_OP_INIT    = 4'h5,
      FPD_OP_CWSTORE = 4'h6,
      FPD_OP_EXAMINE = 4'h7,
      FPD_OP_SAVE    = 4'h8,
      FPD_OP_STORE   = 4'h9
   } fpd_op_t;

   typedef enum logic [1:0] {
      FPD_K_DONE = 2'h0,
      FPD_K_TRAP = 2'h1,
      FPD_K_EXC  = 2'h2
   } fpd_kind_t;

   typedef enum logic [1:0] {
      FPD_S_DETECT = 2'b00,
      FPD_S_IDLE   = 2'b01,
      FPD_S_GAP    = 2'b10
   } fpd_state_t;

   typedef struct packed {
      logic    valid;
      fpd_op_t op;
      logic    has_mem;
      logic    straddle;
      logic    lo_fault;
      logic    hi_fault;
   } fpd_req_t;

   typedef struct packed {
      logic       done;
      logic       err;
      logic       empty;
      logic [3:0] cc;
   } fpd_unit_t;

   typedef struct packed {
      logic       valid;
      fpd_kind_t  kind;
      logic [7:0] vector;
      logic [15:0] cw;
      logic [3:0] cc;
      logic       ptr_valid;
      logic       commit_lo;
      logic       commit_hi;
   } fpd_rsp_t;

   typedef struct packed {
      fpd_state_t  state;
      logic [4:0]  det_cnt;
      logic        detected;
      logic        newer;
      logic        present;
      logic [3:0]  ctrl;
      logic        outstanding;
      logic        err_pending;
      logic        last_mem;
      logic [2:0]  int_stat;
      logic [2:0]  int_mask;
      logic        irq;
      logic        waitreq;
      logic [31:0] rdata;
      fpd_rsp_t    rsp;
      logic        issue;
      fpd_op_t     issue_op;
      logic        ext_err;
   } fpd_main_st_t;
endpackage
`default_nettype wire

// *** hdl/fpd_cc_clean.sv ***
// Condition-code cleanup for the examine operation
`default_nettype none
`include "fpd_consts.svh"
module fpd_cc_clean
(
   // From the arithmetic unit
   input  wire logic       empty,
   input  wire logic [3:0] cc_in,
   // To the dispatcher
   output logic [3:0]      cc_out
);
   // Older units could leak these two codes for an empty register
   always_comb
   begin
      cc_out = cc_in;
      if (empty && (cc_in == `FPD_CC_BAD_A || cc_in == `FPD_CC_BAD_B))
      begin
         cc_out = `FPD_CC_EMPTY; // RL2
      end
   end
endmodule
`default_nettype wire

// *** hdl/fpd_store_split.sv ***
// Partial-commit and pointer-validity decision for memory stores
`default_nettype none
module fpd_store_split
(
   // Store attributes and the memory flag of the previous op
   input  wire logic straddle,
   input  wire logic lo_fault,
   input  wire logic hi_fault,
   input  wire logic prev_mem,
   // Decisions
   output logic      commit_lo,
   output logic      commit_hi,
   output logic      ptr_valid
);
   always_comb
   begin
      // First half may land even if the second half faults
      commit_lo = !lo_fault; // RL7
      commit_hi = !lo_fault && !(straddle && hi_fault); // RL7
      // Pointer only meaningful when the previous op touched memory
      ptr_valid = prev_mem; // RL3
   end
endmodule
`default_nettype wire

// *** hdl/fpd_dispatch.sv ***
// Floating-point dispatch, emulation trap and coprocessor detection with Avalon-MM registers
//
// The Avalon-MM slave port and the address map were left to the implementer.
`default_nettype none
`include "fpd_consts.svh"
module fpd_dispatch
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Avalon-MM slave
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   // Instruction request from the core and its answer
   input  wire fpd_pkg::fpd_req_t  req,
   output fpd_pkg::fpd_rsp_t       rsp,
   // Arithmetic unit or coprocessor
   input  wire fpd_pkg::fpd_unit_t unit,
   input  wire logic               coproc_error_n,
   input  wire logic               fpu_present,
   output logic                    fpu_issue,
   output fpd_pkg::fpd_op_t        fpu_op,
   output logic                    ext_err,
   // Interrupt
   output logic                    irq
);
   localparam int DETECT_CYC = (`FPD_DETECT_NS + `FPD_CLK_NS - 1) / `FPD_CLK_NS;

   fpd_pkg::fpd_main_st_t st;
   fpd_pkg::fpd_main_st_t next_st;
   logic [3:0] cc_clean;
   logic       commit_lo;
   logic       commit_hi;
   logic       ptr_valid;
   logic       is_fp;
   logic       ts_trap;
   logic       blocked;
   logic       accept;
   logic [2:0] ev;
   logic [2:0] w1c;

   fpd_cc_clean u_cc
   (
      .empty  (unit.empty),
      .cc_in  (unit.cc),
      .cc_out (cc_clean)
   );

   fpd_store_split u_split
   (
      .straddle  (req.straddle),
      .lo_fault  (req.lo_fault),
      .hi_fault  (req.hi_fault),
      .prev_mem  (st.last_mem),
      .commit_lo (commit_lo),
      .commit_hi (commit_hi),
      .ptr_valid (ptr_valid)
   );

   always_comb
   begin
      next_st = st;
      accept = 1'b0;
      ev = 3'b000;
      w1c = 3'b000;
      next_st.rsp.valid = 1'b0;
      next_st.issue = 1'b0;
      next_st.waitreq = 1'b1;
      is_fp = !(req.op == fpd_pkg::FPD_OP_LEGACY || req.op == fpd_pkg::FPD_OP_SERIAL
                || req.op == fpd_pkg::FPD_OP_WAIT);
      ts_trap = req.op == fpd_pkg::FPD_OP_WAIT && st.ctrl[`FPD_CTRL_MON]
                && st.ctrl[`FPD_CTRL_TS]; // RL14
      // Only ops that never reach the unit may pass an op still in flight
      blocked = st.outstanding && req.op != fpd_pkg::FPD_OP_LEGACY && !ts_trap
                && !(is_fp && st.ctrl[`FPD_CTRL_EMU]); // RL8 RL9
      if (unit.done)
      begin
         next_st.outstanding = 1'b0;
      end
      case (st.state)
         fpd_pkg::FPD_S_DETECT:
         begin
            if (st.det_cnt == 5'h00)
            begin
               // Coprocessor drives a type level on its error pin after reset
               next_st.detected = 1'b1;
               next_st.newer = !coproc_error_n; // RL10 RL11
               next_st.present = fpu_present;
               next_st.state = fpd_pkg::FPD_S_IDLE;
               ev[`FPD_INT_DETECT] = 1'b1;
            end
            else
            begin
               next_st.det_cnt = st.det_cnt - 5'h01;
            end
         end
         fpd_pkg::FPD_S_IDLE:
         begin
            if (req.valid && !blocked)
            begin
               accept = 1'b1;
               next_st.state = fpd_pkg::FPD_S_GAP;
               next_st.rsp.valid = 1'b1;
               next_st.rsp.kind = fpd_pkg::FPD_K_DONE;
               next_st.rsp.vector = 8'h00;
               next_st.rsp.cw = 16'h0000;
               next_st.rsp.cc = 4'h0;
               next_st.rsp.ptr_valid = 1'b0;
               next_st.rsp.commit_lo = 1'b0;
               next_st.rsp.commit_hi = 1'b0;
               case (req.op)
                  fpd_pkg::FPD_OP_LEGACY:
                  begin
                     // Obsolete opcodes retire with no side effect
                     next_st.rsp.kind = fpd_pkg::FPD_K_DONE; // RL1
                  end
                  fpd_pkg::FPD_OP_SERIAL:
                  begin
                     // Reached only once nothing is in flight
                     next_st.rsp.kind = fpd_pkg::FPD_K_DONE; // RL9
                  end
                  fpd_pkg::FPD_OP_WAIT:
                  begin
                     if (ts_trap)
                     begin
                        // Trap before any unit state is looked at
                        next_st.rsp.kind = fpd_pkg::FPD_K_TRAP; // RL19
                        next_st.rsp.vector = `FPD_VEC_DNA;
                        ev[`FPD_INT_TRAP] = 1'b1;
                     end
                     else if (st.err_pending)
                     begin
                        next_st.rsp.kind = fpd_pkg::FPD_K_EXC; // RL6
                        ev[`FPD_INT_EXC] = 1'b1;
                        if (st.ctrl[`FPD_CTRL_NE])
                        begin
                           next_st.rsp.vector = `FPD_VEC_MF; // RL18
                        end
                        else
                        begin
                           next_st.ext_err = 1'b1; // RL18
                        end
                     end
                  end
                  default:
                  begin
                     if (st.ctrl[`FPD_CTRL_EMU])
                     begin
                        next_st.rsp.kind = fpd_pkg::FPD_K_TRAP; // RL13 RL17
                        next_st.rsp.vector = `FPD_VEC_DNA; // RL17
                        ev[`FPD_INT_TRAP] = 1'b1;
                     end
                     else
                     begin
                        next_st.last_mem = req.has_mem;
                        // Transcendental accuracy and monotonicity belong to the unit
                        if (st.present)
                        begin
                           next_st.issue = 1'b1; // RL13 RL4 RL5
                           next_st.issue_op = req.op;
                           next_st.outstanding = 1'b1; // RL8
                        end
                        case (req.op)
                           fpd_pkg::FPD_OP_INIT:
                           begin
                              // Init clears reporting and never raises an error
                              next_st.err_pending = 1'b0; // RL12
                              next_st.ext_err = 1'b0; // RL12
                           end
                           fpd_pkg::FPD_OP_CWSTORE:
                           begin
                              next_st.rsp.cw = st.present ? `FPD_CW_PRESENT
                                                          : `FPD_CW_NONE; // RL15
                           end
                           fpd_pkg::FPD_OP_EXAMINE:
                           begin
                              next_st.rsp.cc = cc_clean; // RL2
                           end
                           fpd_pkg::FPD_OP_SAVE:
                           begin
                              next_st.rsp.ptr_valid = ptr_valid; // RL3
                           end
                           fpd_pkg::FPD_OP_STORE:
                           begin
                              next_st.rsp.commit_lo = commit_lo; // RL7
                              next_st.rsp.commit_hi = commit_hi; // RL7
                           end
                           default:
                           begin
                              next_st.rsp.cc = 4'h0;
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         fpd_pkg::FPD_S_GAP:
         begin
            // One idle cycle lets the core drop its request
            next_st.state = fpd_pkg::FPD_S_IDLE;
         end
         default:
         begin
            next_st.state = fpd_pkg::FPD_S_DETECT;
         end
      endcase
      // Unit error is set last so it wins over a same-cycle init clear
      if (unit.err)
      begin
         next_st.err_pending = 1'b1;
      end
      if ((avs_read || avs_write) && st.waitreq)
      begin
         next_st.waitreq = 1'b0;
      end
      if (avs_read && st.waitreq)
      begin
         case (avs_address[3:2])
            `FPD_REG_CTRL:    next_st.rdata = {28'h0000000, st.ctrl};
            `FPD_REG_STATUS:  next_st.rdata = {27'h0, st.err_pending, st.outstanding,
                                               st.present, st.newer, st.detected};
            `FPD_REG_INTSTAT: next_st.rdata = {29'h0, st.int_stat};
            `FPD_REG_INTMASK: next_st.rdata = {29'h0, st.int_mask};
            default:          next_st.rdata = 32'h00000000;
         endcase
      end
      if (avs_write && !st.waitreq && avs_byteenable[0])
      begin
         case (avs_address[3:2])
            `FPD_REG_CTRL:    next_st.ctrl = avs_writedata[3:0]; // RL16
            `FPD_REG_INTSTAT: w1c = avs_writedata[2:0];
            `FPD_REG_INTMASK: next_st.int_mask = avs_writedata[2:0];
            default:          next_st.int_mask = st.int_mask;
         endcase
      end
      next_st.int_stat = (st.int_stat & ~w1c) | ev;
      next_st.irq = |(next_st.int_stat & next_st.int_mask);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
         st.state <= fpd_pkg::FPD_S_DETECT;
         st.det_cnt <= 5'(DETECT_CYC - 1);
         st.ctrl <= `FPD_CTRL_RESET;
         st.waitreq <= 1'b1;
         st.issue_op <= fpd_pkg::FPD_OP_LEGACY;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign avs_readdata = st.rdata;
   assign avs_waitrequest = st.waitreq;
   assign rsp = st.rsp;
   assign fpu_issue = st.issue;
   assign fpu_op = st.issue_op;
   assign ext_err = st.ext_err;
   assign irq = st.irq;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_nop_quiet: assert property ( // RL1
      (accept && req.op == fpd_pkg::FPD_OP_LEGACY)
      |=> rsp.valid && rsp.kind == fpd_pkg::FPD_K_DONE && !fpu_issue
          && $stable(st.last_mem) && $stable(st.ctrl))
      else $error("legacy opcode changed state");

   a_exam_clean: assert property ( // RL2
      (accept && req.op == fpd_pkg::FPD_OP_EXAMINE && unit.empty)
      |=> rsp.cc != `FPD_CC_BAD_A && rsp.cc != `FPD_CC_BAD_B)
      else $error("examine reported a forbidden code");

   a_split_commit: assert property ( // RL7
      (accept && req.op == fpd_pkg::FPD_OP_STORE && !st.ctrl[`FPD_CTRL_EMU]
       && req.straddle && !req.lo_fault && req.hi_fault)
      |=> rsp.commit_lo && !rsp.commit_hi)
      else $error("split store commit wrong");

   a_wait_reports: assert property ( // RL6
      (accept && req.op == fpd_pkg::FPD_OP_WAIT && !ts_trap && st.err_pending
       && st.ctrl[`FPD_CTRL_NE])
      |=> rsp.valid && rsp.kind == fpd_pkg::FPD_K_EXC && rsp.vector == `FPD_VEC_MF)
      else $error("wait did not report pending exception");

   a_pin_path: assert property ( // RL18
      (accept && req.op == fpd_pkg::FPD_OP_WAIT && !ts_trap && st.err_pending
       && !st.ctrl[`FPD_CTRL_NE])
      |=> ext_err && rsp.vector == 8'h00)
      else $error("external error path not taken");

   a_sync_hold: assert property ( // RL8
      st.outstanding |=> !fpu_issue)
      else $error("issue while previous op in flight");

   a_serial_drain: assert property ( // RL9
      (st.state == fpd_pkg::FPD_S_IDLE && req.valid && req.op == fpd_pkg::FPD_OP_SERIAL
       && st.outstanding && !unit.done)
      |=> !rsp.valid)
      else $error("serialize finished before drain");

   a_detect_type: assert property ( // RL10
      $rose(st.detected) |-> st.newer == !$past(coproc_error_n) && !$past(rsp.valid))
      else $error("coprocessor type not sampled");

   a_init_quiet: assert property ( // RL12
      (accept && req.op == fpd_pkg::FPD_OP_INIT && !st.ctrl[`FPD_CTRL_EMU] && !unit.err)
      |=> !st.err_pending && !ext_err)
      else $error("init raised an error");

   a_emul_trap: assert property ( // RL17
      (accept && is_fp && st.ctrl[`FPD_CTRL_EMU])
      |=> rsp.kind == fpd_pkg::FPD_K_TRAP && rsp.vector == `FPD_VEC_DNA && !fpu_issue)
      else $error("emulation trap missing");

   a_wait_ts: assert property ( // RL19
      (st.state == fpd_pkg::FPD_S_IDLE && req.valid && ts_trap)
      |=> rsp.kind == fpd_pkg::FPD_K_TRAP && !fpu_issue ##1 !rsp.valid)
      else $error("task-switched wait did not trap");

   a_cw_value: assert property ( // RL15
      (accept && req.op == fpd_pkg::FPD_OP_CWSTORE && !st.ctrl[`FPD_CTRL_EMU])
      |=> rsp.cw == ($past(st.present) ? `FPD_CW_PRESENT : `FPD_CW_NONE))
      else $error("control word store value wrong");

   c_trap: cover property (rsp.valid && rsp.kind == fpd_pkg::FPD_K_TRAP);
   c_exc: cover property (rsp.valid && rsp.kind == fpd_pkg::FPD_K_EXC);
   c_issue: cover property (fpu_issue ##[1:20] unit.done);
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** bench/fpd_unit_model.sv ***
// Behavioural model of the attached arithmetic coprocessor
`default_nettype none
module fpd_unit_model
#(
   parameter int LAT   = 6,
   parameter bit NEWER = 1'b1
)
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // From the dispatcher
   input  wire logic          fpu_issue,
   // Bench controls
   input  wire logic          err_cmd,
   input  wire logic          empty_cfg,
   input  wire logic [3:0]    cc_cfg,
   // To the dispatcher
   output fpd_pkg::fpd_unit_t unit,
   output logic               coproc_error_n,
   output logic               fpu_present,
   // Observation
   output logic               busy,
   output logic               overlap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic       done_q;
   logic       err_q;
   logic       started;
   logic       err_seen;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         {cnt, done_q, err_q, started, err_seen, busy, overlap} <= '0;
      end
      else
      begin
         done_q <= 1'b0;
         err_q  <= 1'b0;
         if (fpu_issue)
         begin
            // A second issue before completion is a dispatcher fault
            if (busy)
               overlap <= 1'b1;
            busy    <= 1'b1;
            started <= 1'b1;
            cnt     <= 8'(LAT);
         end
         else if (busy)
         begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01)
            begin
               busy     <= 1'b0;
               done_q   <= 1'b1;
               err_q    <= err_cmd;
               err_seen <= err_cmd;
            end
         end
      end
   end

   assign unit           = '{done: done_q, err: err_q, empty: empty_cfg, cc: cc_cfg};
   // Type level stands from reset until the first instruction reaches us
   assign coproc_error_n = started ? !err_seen : !NEWER;
   assign fpu_present    = 1'b1;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the floating-point dispatch block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   logic [3:0]         avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   fpd_pkg::fpd_req_t  req;
   fpd_pkg::fpd_rsp_t  rsp;
   fpd_pkg::fpd_rsp_t  r;
   fpd_pkg::fpd_op_t   fop;
   fpd_pkg::fpd_unit_t unit;
   logic               coproc_error_n;
   logic               fpu_present;
   logic               fpu_issue;
   logic               ext_err;
   logic               irq;
   logic               err_cmd;
   logic               empty_cfg;
   logic [3:0]         cc_cfg;
   logic               busy;
   logic               overlap;
   logic               rb;
   logic [31:0]        rd;
   int                 n_errors = 0;
   int                 cmp_count = 0;
   int                 n_iss = 0;
   int                 n;
   logic [4:0]         st [4] = '{5'b10110, 5'b11000, 5'b00111, 5'b10011};
   logic [3:0]         wc [3] = '{4'ha, 4'h8, 4'h2};
   fpd_pkg::fpd_op_t   eo [7] = '{fpd_pkg::FPD_OP_ARITH, fpd_pkg::FPD_OP_TRANSC,
      fpd_pkg::FPD_OP_INIT, fpd_pkg::FPD_OP_CWSTORE, fpd_pkg::FPD_OP_EXAMINE,
      fpd_pkg::FPD_OP_SAVE, fpd_pkg::FPD_OP_STORE};

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk)
      if (fpu_issue === 1'b1)
         n_iss++;

   fpd_dispatch fpd_dispatch_inst (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .req(req), .rsp(rsp), .unit(unit),
      .coproc_error_n(coproc_error_n), .fpu_present(fpu_present), .fpu_issue(fpu_issue),
      .fpu_op(fop), .ext_err(ext_err), .irq(irq));

   fpd_unit_model fpd_unit_model_inst (.core_clk(core_clk), .rst(rst), .fpu_issue(fpu_issue),
      .err_cmd(err_cmd), .empty_cfg(empty_cfg), .cc_cfg(cc_cfg), .unit(unit),
      .coproc_error_n(coproc_error_n), .fpu_present(fpu_present), .busy(busy),
      .overlap(overlap));

   task automatic end_sim;
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rsp(input fpd_pkg::fpd_kind_t k, input logic [7:0] v);
      chk(32'({r.kind, r.vector}), 32'({k, v}));
   endtask

   // Request held until waitrequest is sampled low at a rising edge, released there
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= !w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Valid dropped at the answer edge; the gap edge passes before the next request
   task automatic op(input fpd_pkg::fpd_op_t o, input logic m = 1'b0,
                     input logic [2:0] f = 3'h0);
      req <= '{valid: 1'b1, op: o, has_mem: m, straddle: f[2], lo_fault: f[1], hi_fault: f[0]};
      do
         @(posedge core_clk);
      while (rsp.valid !== 1'b1);
      r  = rsp;
      rb = busy;
      req.valid <= 1'b0;
      @(posedge core_clk);
   endtask

   initial
   begin
      #40000;
      n_errors++;
      end_sim;
   end

   initial
   begin
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
      {req, err_cmd, empty_cfg, cc_cfg} = '0;
      repeat (6) @(posedge core_clk);
      chk(32'({irq, ext_err, rsp.valid, avs_waitrequest}), 32'h1);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      rdchk(4'h4, 32'h7);
      rdchk(4'h8, 32'h4);
      bus(1'b1, 4'h0, 32'hf, 4'he);
      rdchk(4'h0, 32'h0);
      n = n_iss;
      op(fpd_pkg::FPD_OP_LEGACY);
      chk_rsp(fpd_pkg::FPD_K_DONE, 8'h00);
      chk(n_iss, n);
      rdchk(4'h4, 32'h7);
      op(fpd_pkg::FPD_OP_CWSTORE);
      chk(32'(r.cw), 32'h037f);
      chk(32'(fop), 32'(fpd_pkg::FPD_OP_CWSTORE));
      op(fpd_pkg::FPD_OP_ARITH);
      op(fpd_pkg::FPD_OP_SERIAL);
      chk(32'(rb), 32'h0);
      op(fpd_pkg::FPD_OP_ARITH);
      op(fpd_pkg::FPD_OP_TRANSC);
      // Empty examine with the two forbidden codes offered by the unit
      empty_cfg <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         cc_cfg <= i ? 4'hf : 4'hd;
         op(fpd_pkg::FPD_OP_EXAMINE);
         chk(32'(r.cc), 32'h5);
      end
      empty_cfg <= 1'b0;
      foreach (st[i])
      begin
         op(fpd_pkg::FPD_OP_STORE, 1'b1, st[i][4:2]);
         chk(32'({r.commit_lo, r.commit_hi}), 32'(st[i][1:0]));
      end
      op(fpd_pkg::FPD_OP_SAVE, 1'b1);
      chk(32'(r.ptr_valid), 32'h1);
      op(fpd_pkg::FPD_OP_ARITH);
      op(fpd_pkg::FPD_OP_SAVE, 1'b1);
      chk(32'(r.ptr_valid), 32'h0);
      foreach (wc[i])
      begin
         bus(1'b1, 4'h0, 32'(wc[i]));
         n = n_iss;
         op(fpd_pkg::FPD_OP_WAIT);
         chk_rsp(i ? fpd_pkg::FPD_K_DONE : fpd_pkg::FPD_K_TRAP, i ? 8'h00 : 8'h07);
         chk(n_iss, n);
      end
      bus(1'b1, 4'h0, 32'h4);
      err_cmd <= 1'b1;
      op(fpd_pkg::FPD_OP_ARITH);
      // Error is taken when the unit finishes, while the wait is still held off
      op(fpd_pkg::FPD_OP_WAIT);
      err_cmd <= 1'b0;
      chk_rsp(fpd_pkg::FPD_K_EXC, 8'h10);
      chk(32'(ext_err), 32'h0);
      bus(1'b1, 4'h0, 32'h0);
      op(fpd_pkg::FPD_OP_WAIT);
      chk(32'(ext_err), 32'h1);
      op(fpd_pkg::FPD_OP_INIT);
      chk_rsp(fpd_pkg::FPD_K_DONE, 8'h00);
      chk(32'(ext_err), 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      chk(32'(rd[4]), 32'h0);
      // Software setting for a system without a coprocessor
      bus(1'b1, 4'h0, 32'h5);
      n = n_iss;
      foreach (eo[i])
      begin
         op(eo[i]);
         chk_rsp(fpd_pkg::FPD_K_TRAP, 8'h07);
      end
      chk(n_iss, n);
      op(fpd_pkg::FPD_OP_LEGACY);
      chk_rsp(fpd_pkg::FPD_K_DONE, 8'h00);
      bus(1'b0, 4'h8, 32'h0);
      chk(32'(rd[0]), 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b1, 4'hc, 32'h1);
      chk(32'(irq), 32'h1);
      bus(1'b1, 4'h8, 32'h7);
      chk(32'(irq), 32'h0);
      rdchk(4'h8, 32'h0);
      chk(32'(overlap), 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire
